// ---- logic/bls_cfg.svh ----
// constants for the bootstrap load sequencer and its panel-side partner
// assumes a 200 MHz clock shared by both ends
`ifndef BLS_CFG_SVH
`define BLS_CFG_SVH
`define BLS_CLK_PERIOD_PS   5000
`define BLS_ONESHOT_NS      55
// 55 ns is a least width, so round up to whole cycles
`define BLS_ONESHOT_CYC     ((`BLS_ONESHOT_NS * 1000 + `BLS_CLK_PERIOD_PS - 1) / `BLS_CLK_PERIOD_PS)
`define BLS_CNT_W           7
`define BLS_CNT_END         7'h40
`define BLS_ROM_WORDS       32
// entry address 000212 octal, nop 005000 octal, loader base 007000 octal
`define BLS_ENTRY_ADDR      16'h008a
`define BLS_NOP_CODE        16'h0a00
`define BLS_INDEX_ADDR      16'h0e00
// memory address of word n, sector bits chosen arbitrarily
`define BLS_TRAP_BASE       16'h0000
`endif

// ---- logic/bls_pkg.sv ----
// types shared by both ends of the bootstrap loader link
package bls_pkg;
  typedef enum logic [1:0] {
    BLS_IDLE,
    BLS_LOAD,
    BLS_RUN
  } bls_state_type;
  typedef enum logic [1:0] {
    BLS_PASS_REQ,
    BLS_PASS_ADDR,
    BLS_PASS_DATA,
    BLS_PASS_DONE
  } bls_pass_type;
endpackage

// ---- logic/bls_link_if.sv ----
// link between the loader and the processor control and dma logic
// assumes one clock; the bench resolves the shared bus from the enables
`timescale 1ns/1ps
interface bls_link_if;
  logic        loader_start_pulse_n;
  logic        step_mode_n;
  logic        loader_run_request_n;
  logic        const_bus_bit1_n;
  logic        const_bus_bit3_n;
  logic        const_bus_bit7_n;
  logic        const_bus_bit9_n;
  logic        const_bus_bit10_n;
  logic        const_bus_bit11_n;
  logic        const_bus_gate_n;
  logic        program_counter_load_n;
  logic        mem_addr_reg_load_n;
  logic        instr_reg_load_n;
  logic        index_reg_load_n;
  logic        dma_data_ready_n;
  logic        dma_memory_ready_n;
  logic        dma_acknowledge_n;
  logic        dma_interrupt_clock_n;
  logic        system_reset_n;
  logic        trap_in_request_n;
  logic [15:0] bus_ldr_out_n;
  logic [15:0] bus_ldr_oe;
  logic [15:0] bus_cpu_out_n;
  logic [15:0] bus_cpu_oe;
  logic [15:0] shared_bus_line_n;
  modport loader (
    input  loader_start_pulse_n, step_mode_n, dma_data_ready_n,
           dma_memory_ready_n, dma_acknowledge_n, dma_interrupt_clock_n,
           system_reset_n, shared_bus_line_n,
    output loader_run_request_n, const_bus_bit1_n, const_bus_bit3_n,
           const_bus_bit7_n, const_bus_bit9_n, const_bus_bit10_n,
           const_bus_bit11_n, const_bus_gate_n, program_counter_load_n,
           mem_addr_reg_load_n, instr_reg_load_n, index_reg_load_n,
           trap_in_request_n, bus_ldr_out_n, bus_ldr_oe
  );
  modport cpu (
    input  loader_run_request_n, const_bus_bit1_n, const_bus_bit3_n,
           const_bus_bit7_n, const_bus_bit9_n, const_bus_bit10_n,
           const_bus_bit11_n, const_bus_gate_n, program_counter_load_n,
           mem_addr_reg_load_n, instr_reg_load_n, index_reg_load_n,
           trap_in_request_n, bus_ldr_out_n, bus_ldr_oe, shared_bus_line_n,
    output loader_start_pulse_n, step_mode_n, dma_data_ready_n,
           dma_memory_ready_n, dma_acknowledge_n, dma_interrupt_clock_n,
           system_reset_n, bus_cpu_out_n, bus_cpu_oe
  );
endinterface

// ---- logic/bls_loader.sv ----
// loader end: load sequence, register programming, start/run
// assumes the link interface, one clock, inputs synchronous to CLK
`timescale 1ns/1ps
`include "bls_cfg.svh"
module bls_loader
  import bls_pkg::*;
(
  input  wire logic  CLK,
  input  wire logic  RST_N,
  bls_link_if.loader LINK,
  input  wire logic [7:0] ROM_BYTE,
  output logic      [4:0] ROM_ADDR,
  output logic            BUSY
);
  bls_state_type    state;
  bls_pass_type     pass;
  logic [`BLS_CNT_W-1:0] cnt;
  logic [7:0]       hold_byte;
  logic             start_q1;
  logic             start_q2;
  logic             start_q3;
  logic             start_edge;
  logic             srst;
  logic             spix;
  logic             g_p;
  logic             g_i;
  logic             g_x;
  logic [15:0]      trap_addr;

  // start pulse is already synchronous; three stages give a clean edge
  always_ff @(posedge CLK) begin
    if (!RST_N || srst) begin
      start_q1 <= 1'b1;
      start_q2 <= 1'b1;
      start_q3 <= 1'b1;
    end else begin
      start_q1 <= LINK.loader_start_pulse_n;
      start_q2 <= start_q1;
      start_q3 <= start_q2;
    end
  end
  assign start_edge = start_q3 && !start_q2;

  // system reset from dma side and board reset both clear everything
  assign srst = !LINK.system_reset_n;

  // top sequence: idle, load with register programming, start/run
  always_ff @(posedge CLK) begin
    if (!RST_N || srst) begin
      state <= BLS_IDLE;
    end else begin
      case (state)
        BLS_IDLE: begin
          // presses outside step mode or while busy are dropped
          if (start_edge && !LINK.step_mode_n) begin
            state <= BLS_LOAD;
          end
        end
        BLS_LOAD: begin
          if (cnt == `BLS_CNT_END) begin
            state <= BLS_RUN;
          end
        end
        BLS_RUN: begin
          state <= BLS_IDLE;
        end
        default: begin
          state <= BLS_IDLE;
        end
      endcase
    end
  end

  // one word pass: request, address phase, data phase
  always_ff @(posedge CLK) begin
    if (!RST_N || srst || state != BLS_LOAD) begin
      pass <= BLS_PASS_REQ;
    end else begin
      case (pass)
        BLS_PASS_REQ: begin
          if (!LINK.dma_acknowledge_n) begin
            pass <= BLS_PASS_ADDR;
          end
        end
        BLS_PASS_ADDR: begin
          if (!LINK.dma_memory_ready_n) begin
            pass <= BLS_PASS_DATA;
          end
        end
        BLS_PASS_DATA: begin
          if (!LINK.dma_data_ready_n) begin
            pass <= BLS_PASS_DONE;
          end
        end
        BLS_PASS_DONE: begin
          pass <= BLS_PASS_REQ;
        end
        default: begin
          pass <= BLS_PASS_REQ;
        end
      endcase
    end
  end

  // counter steps on acknowledge and on data ready: two per word
  always_ff @(posedge CLK) begin
    if (!RST_N || srst || state == BLS_IDLE) begin
      cnt <= '0;
    end else if (state == BLS_LOAD && cnt != `BLS_CNT_END &&
                 ((pass == BLS_PASS_REQ && !LINK.dma_acknowledge_n) ||
                  (pass == BLS_PASS_DATA && !LINK.dma_data_ready_n))) begin
      cnt <= cnt + 1'b1;
    end
  end

  // even byte is buffered at the request, before the count moves on
  always_ff @(posedge CLK) begin
    if (!RST_N || srst) begin
      hold_byte <= 8'h00;
    end else if (state == BLS_LOAD && pass == BLS_PASS_REQ) begin
      hold_byte <= ROM_BYTE;
    end
  end

  assign ROM_ADDR = cnt[4:0];
  assign BUSY = state != BLS_IDLE;
  // word address uses counter bits 1..5
  assign trap_addr = `BLS_TRAP_BASE | {11'h000, cnt[5:1]};

  // trap request stands from pass start until acknowledge
  assign LINK.trap_in_request_n =
    !(state == BLS_LOAD && pass == BLS_PASS_REQ && cnt != `BLS_CNT_END);

  // bus: address in address phase, odd rom byte low and held byte high
  always_comb begin
    LINK.bus_ldr_out_n = 16'hffff;
    LINK.bus_ldr_oe = 16'h0000;
    if (state == BLS_LOAD && pass == BLS_PASS_ADDR) begin
      LINK.bus_ldr_out_n = ~trap_addr;
      LINK.bus_ldr_oe = 16'hffff;
    end else if (state == BLS_LOAD && pass == BLS_PASS_DATA) begin
      LINK.bus_ldr_out_n = ~{hold_byte, ROM_BYTE};
      LINK.bus_ldr_oe = 16'hffff;
    end
  end

  // register programming decodes the same counter in parallel
  assign spix = (state == BLS_LOAD) && cnt[3] && !cnt[2] && cnt[1];
  assign g_p = cnt[4] && !cnt[5];
  assign g_i = !cnt[4] && cnt[5];
  assign g_x = cnt[4] && cnt[5];

  // hard-wired constants; unused bits of 000212 and friends stay high
  assign LINK.const_bus_bit1_n  = !(state == BLS_LOAD && g_p);
  assign LINK.const_bus_bit3_n  = !(state == BLS_LOAD && g_p);
  assign LINK.const_bus_bit7_n  = !(state == BLS_LOAD && g_p);
  assign LINK.const_bus_bit9_n  = !(state == BLS_LOAD && (g_i || g_x));
  assign LINK.const_bus_bit10_n = !(state == BLS_LOAD && g_x);
  assign LINK.const_bus_bit11_n = !(state == BLS_LOAD && (g_i || g_x));
  assign LINK.const_bus_gate_n =
    !(state == BLS_LOAD && (g_p || g_i || g_x));
  assign LINK.program_counter_load_n = !(spix && g_p);
  assign LINK.mem_addr_reg_load_n    = !(spix && g_p);
  assign LINK.instr_reg_load_n       = !(spix && g_i);
  assign LINK.index_reg_load_n       = !(spix && g_x);

  // run request is one cycle, just before the loader clears
  assign LINK.loader_run_request_n = !(state == BLS_RUN);
endmodule

// ---- logic/bls_panel.sv ----
// processor-side end: panel latch and one-shot, plus a simple dma model
// assumes one clock; the button and step level come from user ports
`timescale 1ns/1ps
`include "bls_cfg.svh"
module bls_panel
  import bls_pkg::*;
(
  input  wire logic  CLK,
  input  wire logic  RST_N,
  bls_link_if.cpu    LINK,
  input  wire logic  BUTTON_PRESS_N,
  input  wire logic  STEP_MODE,
  input  wire logic  LOADER_BUSY,
  output logic       RUN_MODE,
  output logic [15:0] WORD_DATA,
  output logic [15:0] WORD_ADDR,
  output logic        WORD_VALID
);
  localparam int OS_CYC = `BLS_ONESHOT_CYC;
  logic       press_latch;
  logic       press_latch_q;
  logic [4:0] press_oneshot;
  logic [1:0] dma_ph;
  logic       run;

  // press held in a latch until the loader run request clears it
  always_ff @(posedge CLK) begin
    if (!RST_N || !LINK.loader_run_request_n) begin
      press_latch <= 1'b0;
    end else if (!BUTTON_PRESS_N && STEP_MODE && !LOADER_BUSY && !run) begin
      press_latch <= 1'b1;
    end
  end

  // one-shot fires on the latch rising, 55 ns of cycles
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      press_latch_q <= 1'b0;
      press_oneshot <= 5'h00;
    end else begin
      press_latch_q <= press_latch;
      if (press_latch && !press_latch_q) begin
        press_oneshot <= 5'(OS_CYC);
      end else if (press_oneshot != 5'h00) begin
        press_oneshot <= press_oneshot - 5'h01;
      end
    end
  end
  assign LINK.loader_start_pulse_n =
    !(press_latch && press_oneshot != 5'h00);

  // run mode set by the loader request, step mode entry clears it
  always_ff @(posedge CLK) begin
    if (!RST_N || STEP_MODE && run && LINK.loader_run_request_n) begin
      run <= 1'b0;
    end else if (!LINK.loader_run_request_n) begin
      run <= 1'b1;
    end
  end
  assign RUN_MODE = run;
  assign LINK.step_mode_n = !(STEP_MODE && !run);

  // dma: one idle cycle before ack, so the trap must be held to get it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dma_ph <= 2'h0;
      WORD_DATA <= 16'h0000;
      WORD_ADDR <= 16'h0000;
      WORD_VALID <= 1'b0;
    end else begin
      WORD_VALID <= 1'b0;
      case (dma_ph)
        2'h0: if (!LINK.trap_in_request_n) dma_ph <= 2'h1;
        2'h1: dma_ph <= 2'h2;
        2'h2: begin
          WORD_ADDR <= ~LINK.shared_bus_line_n;
          dma_ph <= 2'h3;
        end
        default: begin
          WORD_DATA <= ~LINK.shared_bus_line_n;
          WORD_VALID <= 1'b1;
          dma_ph <= 2'h0;
        end
      endcase
    end
  end
  assign LINK.dma_acknowledge_n     = !(dma_ph == 2'h1);
  assign LINK.dma_memory_ready_n    = !(dma_ph == 2'h2);
  assign LINK.dma_data_ready_n      = !(dma_ph == 2'h3);
  assign LINK.dma_interrupt_clock_n = 1'b1;
  assign LINK.system_reset_n        = RST_N;
  assign LINK.bus_cpu_out_n         = 16'hffff;
  assign LINK.bus_cpu_oe            = 16'h0000;
endmodule

// ---- bench/bls_link_monitor.sv ----
// checker for the loader link, watching the interface signals only
// assumes one clock and the bench instantiating it beside the link
`timescale 1ns/1ps
module bls_link_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic loader_start_pulse_n,
  input wire logic step_mode_n,
  input wire logic loader_run_request_n,
  input wire logic const_bus_gate_n,
  input wire logic const_bus_bit7_n,
  input wire logic program_counter_load_n,
  input wire logic mem_addr_reg_load_n,
  input wire logic instr_reg_load_n,
  input wire logic index_reg_load_n,
  input wire logic dma_acknowledge_n,
  input wire logic trap_in_request_n
);
  logic       trap_q;
  logic [6:0] words;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // last trap level, so a new request shows as a fall
  always_ff @(posedge CLK) begin
    trap_q <= RST_N ? trap_in_request_n : 1'b1;
  end
  // words requested since start; cleared by reset or run request
  always_ff @(posedge CLK) begin
    if (!RST_N || !loader_run_request_n) begin
      words <= 7'h00;
    end else if (trap_q && !trap_in_request_n) begin
      words <= words + 7'h01;
    end
  end
  sequence s_start;
    $fell(loader_start_pulse_n) && !step_mode_n;
  endsequence
  sequence s_run;
    $fell(loader_run_request_n);
  endsequence
  property p_start_go;
    s_start |-> ##[1:8] !trap_in_request_n;
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("no trap request after start");
  property p_trap_hold;
    !trap_in_request_n && dma_acknowledge_n |=> !trap_in_request_n;
  endproperty
  a_trap_hold: assert property (p_trap_hold)
    else $error("trap request dropped before acknowledge");
  property p_pl_pair;
    program_counter_load_n == mem_addr_reg_load_n;
  endproperty
  a_pl_pair: assert property (p_pl_pair)
    else $error("program counter and address strobes differ");
  property p_pl_entry;
    !program_counter_load_n |-> !const_bus_gate_n && !const_bus_bit7_n;
  endproperty
  a_pl_entry: assert property (p_pl_entry)
    else $error("entry address not on constant bus");
  property p_run_pulse;
    s_run |=> loader_run_request_n;
  endproperty
  a_run_pulse: assert property (p_run_pulse)
    else $error("run request wider than one cycle");
  property p_run_quiet;
    !loader_run_request_n |-> trap_in_request_n && const_bus_gate_n;
  endproperty
  a_run_quiet: assert property (p_run_quiet)
    else $error("run request while sequences active");
  property p_strobe_one;
    $onehot0({~program_counter_load_n, ~instr_reg_load_n,
              ~index_reg_load_n});
  endproperty
  a_strobe_one: assert property (p_strobe_one)
    else $error("two register strobes at once");
  property p_word_count;
    s_run |-> words == 7'h20;
  endproperty
  a_word_count: assert property (p_word_count)
    else $error("run request after wrong word count");
endmodule

// ---- bench/testbench.sv ----
// self-checking bench: loader and panel joined by the link interface
// assumes a shared 200 MHz clock; the bench resolves the shared bus
`timescale 1ns/1ps
`include "bls_cfg.svh"
module testbench;
  logic        clk;
  logic        rst_n;
  logic        press_n;
  logic        step;
  logic        busy;
  logic        run_mode;
  logic        word_valid;
  logic [15:0] word_data;
  logic [15:0] word_addr;
  logic [4:0]  rom_addr;
  logic [7:0]  rom_byte;
  int          errors;
  int          num_checks;
  bls_link_if link ();
  // wired-and of both drivers, released lines float high
  assign link.shared_bus_line_n = (link.bus_ldr_out_n | ~link.bus_ldr_oe)
                                & (link.bus_cpu_out_n | ~link.bus_cpu_oe);
  // each rom byte carries its own address, so order slips show
  assign rom_byte = {rom_addr, 3'h3};
  bls_loader bls_loader_i (.CLK(clk), .RST_N(rst_n), .LINK(link.loader),
    .ROM_BYTE(rom_byte), .ROM_ADDR(rom_addr), .BUSY(busy));
  bls_panel bls_panel_i (.CLK(clk), .RST_N(rst_n), .LINK(link.cpu),
    .BUTTON_PRESS_N(press_n), .STEP_MODE(step), .LOADER_BUSY(busy),
    .RUN_MODE(run_mode), .WORD_DATA(word_data), .WORD_ADDR(word_addr),
    .WORD_VALID(word_valid));
  bls_link_monitor bls_link_monitor_i (.CLK(clk), .RST_N(rst_n),
    .loader_start_pulse_n(link.loader_start_pulse_n),
    .step_mode_n(link.step_mode_n),
    .loader_run_request_n(link.loader_run_request_n),
    .const_bus_gate_n(link.const_bus_gate_n),
    .const_bus_bit7_n(link.const_bus_bit7_n),
    .program_counter_load_n(link.program_counter_load_n),
    .mem_addr_reg_load_n(link.mem_addr_reg_load_n),
    .instr_reg_load_n(link.instr_reg_load_n),
    .index_reg_load_n(link.index_reg_load_n),
    .dma_acknowledge_n(link.dma_acknowledge_n),
    .trap_in_request_n(link.trap_in_request_n));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] rom_of(input int a);
    return {a[4:0], 3'h3};
  endfunction
  // word the hard-wired constant bits put on the register path
  function automatic logic [15:0] const_word();
    return ~{4'hf, link.const_bus_bit11_n, link.const_bus_bit10_n,
             link.const_bus_bit9_n, 1'b1, link.const_bus_bit7_n, 3'h7,
             link.const_bus_bit3_n, 1'b1, link.const_bus_bit1_n, 1'b1};
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // inputs always move 1 ns after the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // press with the processor out of step mode
  task automatic t_refuse();
    logic seen;
    seen = 1'b0;
    press_n = 1'b0;
    repeat (40) begin
      cycles(1);
      seen = seen | busy;
    end
    press_n = 1'b1;
    check("busy_refused", {15'h0, seen}, 16'h0);
  endtask
  // start in step mode, press again while busy at word 5, collect n words
  task automatic t_load(input int n);
    int k;
    int c;
    k = 0;
    step = 1'b1;
    cycles(2);
    press_n = 1'b0;
    for (c = 0; c < 4000 && k < n; c++) begin
      cycles(1);
      if (busy === 1'b1) begin
        step = (k < 8) ? 1'b1 : 1'b0;
        press_n = (k == 5) ? 1'b0 : 1'b1;
      end
      if (link.program_counter_load_n === 1'b0)
        check("entry", const_word(), `BLS_ENTRY_ADDR);
      if (link.instr_reg_load_n === 1'b0)
        check("nop", const_word(), `BLS_NOP_CODE);
      if (link.index_reg_load_n === 1'b0)
        check("index", const_word(), `BLS_INDEX_ADDR);
      if (word_valid === 1'b1) begin
        check("addr", word_addr, `BLS_TRAP_BASE | 16'(k));
        check("data", word_data, {rom_of(2*k), rom_of(2*k+1)});
        k++;
      end
    end
    if (k < n) begin
      errors++;
      complete_run();
    end
  endtask
  // a full load ends in run mode with the loader idle
  task automatic t_finish();
    int c;
    for (c = 0; c < 200 && busy !== 1'b0; c++) begin
      cycles(1);
    end
    if (c >= 200) begin
      errors++;
      complete_run();
    end
    cycles(3);
    check("run_mode", {15'h0, run_mode}, 16'h1);
    check("busy_end", {15'h0, busy}, 16'h0);
  endtask
  // reset mid-load, then a full load must restart at word zero
  task automatic t_reset_mid();
    t_load(4);
    rst_n = 1'b0;
    cycles(2);
    check("busy_rst", {15'h0, busy}, 16'h0);
    check("trap_rst", {15'h0, link.trap_in_request_n}, 16'h1);
    rst_n = 1'b1;
    t_load(32);
    t_finish();
  endtask
  // main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    press_n = 1'b1;
    step = 1'b0;
    cycles(20);
    rst_n = 1'b1;
    t_refuse();
    t_load(32);
    t_finish();
    t_reset_mid();
    complete_run();
  end
endmodule
